// ==== logic/tcp_pkg.sv ====
`default_nettype none
package tcp_pkg;
  localparam int TCP_NUM_INST = 4;
  localparam int TCP_CNT_W = 16;
  localparam int TCP_EVT_W = 3;
  localparam int TCP_ADR_W = 8;

  // Per-instance register window, byte offsets
  localparam logic [7:0] TCP_INST_STRIDE = 8'h20;
  localparam logic [4:0] TCP_OFS_CTRL = 5'h00;
  localparam logic [4:0] TCP_OFS_PERIOD = 5'h04;
  localparam logic [4:0] TCP_OFS_COMPARE = 5'h08;
  localparam logic [4:0] TCP_OFS_DEAD = 5'h0c;
  localparam logic [4:0] TCP_OFS_COUNT = 5'h10;
  localparam logic [4:0] TCP_OFS_CAPTURE = 5'h14;
  // Shared interrupt registers
  localparam logic [7:0] TCP_OFS_IRQ_STATUS = 8'h80;
  localparam logic [7:0] TCP_OFS_IRQ_MASK = 8'h84;

  // Event bit positions inside each instance's status group
  localparam int TCP_EVT_TC = 0;
  localparam int TCP_EVT_CMP = 1;
  localparam int TCP_EVT_CAP = 2;

  localparam logic [15:0] TCP_RST_PERIOD = 16'hffff;
  localparam logic [15:0] TCP_RST_COMPARE = 16'h0000;
  localparam logic [7:0] TCP_RST_DEAD = 8'h00;
  localparam logic [11:0] TCP_RST_CTRL = 12'h000;
  localparam logic [11:0] TCP_RST_MASK = 12'h000;
  localparam int TCP_PRESCALE = 8;

  typedef enum logic [1:0] {
    MODE_FREE = 2'b00,
    MODE_ONESHOT = 2'b01,
    MODE_GATED = 2'b10
  } tcp_mode_e;

  typedef enum logic [2:0] {
    CMP_BELOW = 3'b000,
    CMP_AT_OR_BELOW = 3'b001,
    CMP_MATCHING = 3'b010,
    CMP_AT_OR_ABOVE = 3'b011,
    CMP_ABOVE = 3'b100
  } tcp_rel_e;

  typedef enum logic [1:0] {
    CLK_SYS = 2'b00,
    CLK_PRESCALED = 2'b01,
    CLK_SRC_RISE = 2'b10,
    CLK_SRC_FALL = 2'b11
  } tcp_clk_e;

  typedef enum logic {
    ST_IDLE = 1'b0,
    ST_RUN = 1'b1
  } tcp_run_e;

  // Control register, bit 0 upward: start, mode, rel, clkSel, compEn, irqSel
  typedef struct packed {
    logic [2:0] irqSel;
    logic compEn;
    tcp_clk_e clkSel;
    tcp_rel_e rel;
    tcp_mode_e mode;
    logic start;
  } tcp_ctrl_s;

  typedef struct packed {
    logic cap;
    logic cmp;
    logic tc;
  } tcp_evt_s;
endpackage
`default_nettype wire

// ==== logic/tcp_timer_top.sv ====
// Function
// - Each counter is a 16-bit register that only counts down on each active edge of its selected clock.
// - Four independent timer units exist, each with its own configuration and outputs.
// - Each unit picks its counting clock from several sources through its own clock select field.
// - All unit inputs and outputs are plain routable signals so any pin or internal logic can reach them.
// - Each unit drives a compare output, a terminal count output, an optional complementary output and an irq line.
// - Three run modes exist: free running, one shot, and counting under an enable input.
// - A reset input restarts the counter and a capture input latches the current count.
// - Capture keeps the full 16-bit count with no bits dropped.
// - The kill input forces the compare-driven outputs inactive for as long as it is asserted.
// - The comparator offers below, at or below, matching, at or above and above relations.
// - The period is loaded into the counter on start, on reset and at terminal count.
// - The interrupt can be raised on terminal count, on compare true or on capture, as configured.
// - In gated mode the counter decrements only while the enable input is high and holds otherwise.
// - In one-shot mode the counter reloads the period at terminal count and then stops instead of continuing.
// - Complementary outputs have a deadband in which neither is active around each transition.
//
// Design decisions made here: the placing of the registers and register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none
module tcp_timer_top
  import tcp_pkg::*;
#(
  parameter int NUM_INST = TCP_NUM_INST,
  parameter int PRESCALE = TCP_PRESCALE
) (
  input wire logic clock, // System clock
  input wire logic rst_b, // Async reset, active low
  input wire logic clkEn, // Freezes all state when low
  input wire logic wb_cyc_i, // Wishbone cycle
  input wire logic wb_stb_i, // Wishbone strobe
  input wire logic wb_we_i, // Wishbone write
  input wire logic [TCP_ADR_W-1:0] wb_adr_i, // Byte address
  input wire logic [3:0] wb_sel_i, // Byte enables
  input wire logic [31:0] wb_dat_i, // Write data
  output logic [31:0] wb_dat_o, // Read data
  output logic wb_ack_o, // Acknowledge
  input wire logic [NUM_INST-1:0] srcClk, // Routed count clock sources
  input wire logic [NUM_INST-1:0] tmrEn, // Count enable for gated mode
  input wire logic [NUM_INST-1:0] tmrRst, // Counter restart
  input wire logic [NUM_INST-1:0] tmrCap, // Capture strobe
  input wire logic [NUM_INST-1:0] tmrKill, // Compare output kill
  output logic [NUM_INST-1:0] cmpOut, // Compare output with deadband
  output logic [NUM_INST-1:0] cmpComp, // Complementary compare output
  output logic [NUM_INST-1:0] tcOut, // Terminal count pulse
  output logic [NUM_INST-1:0] irqReq, // Per-unit interrupt request
  output logic irq // Combined interrupt
);
  localparam int SW = NUM_INST * TCP_EVT_W;
  localparam int PW = $clog2(PRESCALE + 1);

  tcp_ctrl_s ctrl [NUM_INST];
  logic [TCP_CNT_W-1:0] period [NUM_INST];
  logic [TCP_CNT_W-1:0] compare [NUM_INST];
  logic [7:0] dead [NUM_INST];
  logic [TCP_CNT_W-1:0] count [NUM_INST];
  logic [TCP_CNT_W-1:0] capture [NUM_INST];
  logic [SW-1:0] irqStatus;
  logic [SW-1:0] irqMask;
  logic [SW-1:0] evtAll;
  logic [SW-1:0] clrMask;
  logic [31:0] rdData;
  logic [PW-1:0] preCnt;
  logic preTick;
  logic wrCommit;

  function automatic logic relTrue(input tcp_rel_e rel, input logic [TCP_CNT_W-1:0] a,
                                   input logic [TCP_CNT_W-1:0] b);
    case (rel)
      CMP_BELOW: relTrue = a < b;
      CMP_AT_OR_BELOW: relTrue = a <= b;
      CMP_MATCHING: relTrue = a == b;
      CMP_AT_OR_ABOVE: relTrue = a >= b;
      CMP_ABOVE: relTrue = a > b;
      default: relTrue = 1'b0;
    endcase
  endfunction

  function automatic logic [31:0] mergeBytes(input logic [31:0] old, input logic [31:0] wr,
                                             input logic [3:0] sel);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        res[8*b +: 8] = wr[8*b +: 8];
      end
    end
    mergeBytes = res;
  endfunction

  // Narrow merges keep the upper lanes from leaking into short registers
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wr, input logic [3:0] sel);
    logic [31:0] full;
    full = mergeBytes(32'(old), wr, sel);
    merge16 = full[15:0];
  endfunction

  function automatic logic [11:0] merge12(input logic [11:0] old, input logic [31:0] wr, input logic [3:0] sel);
    logic [31:0] full;
    full = mergeBytes(32'(old), wr, sel);
    merge12 = full[11:0];
  endfunction

  function automatic logic [7:0] merge8(input logic [7:0] old, input logic [31:0] wr, input logic [3:0] sel);
    logic [31:0] full;
    full = mergeBytes(32'(old), wr, sel);
    merge8 = full[7:0];
  endfunction

  // Instance window hit: true when the word-aligned address belongs to instance k
  function automatic logic instHit(input logic [TCP_ADR_W-1:0] adr, input int k);
    instHit = (adr[7:5] == 3'(k)) && (adr[1:0] == 2'b00);
  endfunction

  assign wrCommit = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o;

  // Shared prescaled tick source
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      preCnt <= '0;
      preTick <= 1'b0;
    end else if (clkEn) begin
      preTick <= (preCnt == PW'(PRESCALE - 1));
      preCnt <= (preCnt == PW'(PRESCALE - 1)) ? '0 : preCnt + PW'(1);
    end
  end

  always_comb begin
    rdData = 32'h0000_0000;
    for (int k = 0; k < NUM_INST; k++) begin
      if (instHit(wb_adr_i, k)) begin
        case (wb_adr_i[4:0])
          TCP_OFS_CTRL: rdData = 32'(ctrl[k]);
          TCP_OFS_PERIOD: rdData = 32'(period[k]);
          TCP_OFS_COMPARE: rdData = 32'(compare[k]);
          TCP_OFS_DEAD: rdData = 32'(dead[k]);
          TCP_OFS_COUNT: rdData = 32'(count[k]);
          TCP_OFS_CAPTURE: rdData = 32'(capture[k]);
          default: rdData = 32'h0000_0000;
        endcase
      end
    end
    if (wb_adr_i == TCP_OFS_IRQ_STATUS) begin
      rdData = 32'(irqStatus);
    end
    if (wb_adr_i == TCP_OFS_IRQ_MASK) begin
      rdData = 32'(irqMask);
    end
  end

  // Bus slave and writable registers; unmapped addresses ack and read zero
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
      irqMask <= SW'(TCP_RST_MASK);
      for (int k = 0; k < NUM_INST; k++) begin
        ctrl[k] <= tcp_ctrl_s'(TCP_RST_CTRL);
        period[k] <= TCP_RST_PERIOD;
        compare[k] <= TCP_RST_COMPARE;
        dead[k] <= TCP_RST_DEAD;
      end
    end else if (clkEn) begin
      wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
      if (wb_cyc_i & wb_stb_i & ~wb_ack_o) begin
        wb_dat_o <= rdData;
      end
      if (wrCommit) begin
        for (int k = 0; k < NUM_INST; k++) begin
          if (instHit(wb_adr_i, k)) begin
            case (wb_adr_i[4:0])
              TCP_OFS_CTRL: ctrl[k] <= tcp_ctrl_s'(merge12(12'(ctrl[k]), wb_dat_i, wb_sel_i));
              TCP_OFS_PERIOD: period[k] <= merge16(period[k], wb_dat_i, wb_sel_i);
              TCP_OFS_COMPARE: compare[k] <= merge16(compare[k], wb_dat_i, wb_sel_i);
              TCP_OFS_DEAD: dead[k] <= merge8(dead[k], wb_dat_i, wb_sel_i);
              default: ;
            endcase
          end
        end
        if (wb_adr_i == TCP_OFS_IRQ_MASK) begin
          irqMask <= SW'(mergeBytes(32'(irqMask), wb_dat_i, wb_sel_i));
        end
      end
    end
  end

  always_comb begin
    clrMask = '0;
    if (wrCommit && wb_adr_i == TCP_OFS_IRQ_STATUS) begin
      clrMask = SW'(mergeBytes(32'h0000_0000, wb_dat_i, wb_sel_i));
    end
  end

  // Sticky status: a new event in the clearing cycle survives
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      irqStatus <= '0;
      irq <= 1'b0;
    end else if (clkEn) begin
      irqStatus <= (irqStatus & ~clrMask) | evtAll;
      irq <= |(((irqStatus & ~clrMask) | evtAll) & irqMask);
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < NUM_INST; gi++) begin : g_unit
      tcp_run_e runState;
      tcp_evt_s evt;
      logic startQ, rstQ, capQ, srcQ;
      logic tick, startRise, rstRise, capRise, cmpRaw, cmpPrev;
      logic [7:0] dbCnt;
      logic [SW-1:0] grpMask;

      assign startRise = ctrl[gi].start & ~startQ;
      assign rstRise = tmrRst[gi] & ~rstQ;
      assign capRise = tmrCap[gi] & ~capQ;
      assign cmpRaw = relTrue(ctrl[gi].rel, count[gi], compare[gi]);
      assign grpMask = SW'({TCP_EVT_W{1'b1}}) << (gi * TCP_EVT_W);
      assign evtAll[gi*TCP_EVT_W +: TCP_EVT_W] = {evt.cap, evt.cmp, evt.tc} & ctrl[gi].irqSel;

      always_comb begin
        case (ctrl[gi].clkSel)
          CLK_SYS: tick = 1'b1;
          CLK_PRESCALED: tick = preTick;
          CLK_SRC_RISE: tick = srcClk[gi] & ~srcQ;
          CLK_SRC_FALL: tick = ~srcClk[gi] & srcQ;
          default: tick = 1'b0;
        endcase
      end

      // Routed inputs are plain synchronous levels; restart, capture and source clock are edge detected here
      always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
          startQ <= 1'b0;
          rstQ <= 1'b0;
          capQ <= 1'b0;
          srcQ <= 1'b0;
        end else if (clkEn) begin
          startQ <= ctrl[gi].start;
          rstQ <= tmrRst[gi];
          capQ <= tmrCap[gi];
          srcQ <= srcClk[gi];
        end
      end

      // Down counter and run control
      always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
          count[gi] <= TCP_RST_PERIOD;
          runState <= ST_IDLE;
          evt.tc <= 1'b0;
          tcOut[gi] <= 1'b0;
        end else if (clkEn) begin
          evt.tc <= 1'b0;
          tcOut[gi] <= 1'b0;
          if (!ctrl[gi].start) begin
            runState <= ST_IDLE;
            if (rstRise) begin
              count[gi] <= period[gi];
            end
          end else if (startRise || rstRise) begin
            count[gi] <= period[gi];
            runState <= ST_RUN;
          end else begin
            case (runState)
              ST_RUN: begin
                if (tick && (ctrl[gi].mode != MODE_GATED || tmrEn[gi])) begin
                  if (count[gi] == '0) begin
                    count[gi] <= period[gi];
                    evt.tc <= 1'b1;
                    tcOut[gi] <= 1'b1;
                    if (ctrl[gi].mode == MODE_ONESHOT) begin
                      runState <= ST_IDLE;
                    end
                  end else begin
                    count[gi] <= count[gi] - 16'h0001;
                  end
                end
              end
              ST_IDLE: runState <= ST_IDLE;
              default: runState <= ST_IDLE;
            endcase
          end
        end
      end

      always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
          capture[gi] <= 16'h0000;
          evt.cap <= 1'b0;
        end else if (clkEn) begin
          evt.cap <= capRise;
          if (capRise) begin
            capture[gi] <= count[gi];
          end
        end
      end

      // Deadband: both outputs idle for dead[]+1 cycles from each compare edge
      always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
          cmpPrev <= 1'b0;
          evt.cmp <= 1'b0;
          dbCnt <= 8'h00;
          cmpOut[gi] <= 1'b0;
          cmpComp[gi] <= 1'b0;
        end else if (clkEn) begin
          cmpPrev <= cmpRaw;
          evt.cmp <= cmpRaw & ~cmpPrev;
          if (cmpRaw != cmpPrev) begin
            dbCnt <= dead[gi];
          end else if (dbCnt != 8'h00) begin
            dbCnt <= dbCnt - 8'h01;
          end
          if (tmrKill[gi] || cmpRaw != cmpPrev || dbCnt != 8'h00) begin
            cmpOut[gi] <= 1'b0;
            cmpComp[gi] <= 1'b0;
          end else begin
            cmpOut[gi] <= cmpRaw;
            cmpComp[gi] <= ~cmpRaw & ctrl[gi].compEn;
          end
        end
      end

      always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
          irqReq[gi] <= 1'b0;
        end else if (clkEn) begin
          irqReq[gi] <= |(((irqStatus & ~clrMask) | evtAll) & irqMask & grpMask);
        end
      end
    end
  endgenerate
endmodule
`default_nettype wire

// ==== sim/tcp_timer_props.sv ====
`timescale 1ns/1ps
`default_nettype none
module tcp_timer_props #(
  parameter int NUM_INST = 4
) (
  input wire logic clock, // System clock
  input wire logic rst_b, // Async reset
  input wire logic clkEn, // Run enable
  input wire logic wb_cyc_i, // Bus cycle
  input wire logic wb_stb_i, // Bus strobe
  input wire logic [31:0] wb_dat_o, // Read data
  input wire logic wb_ack_o, // Acknowledge
  input wire logic [NUM_INST-1:0] tmrKill, // Kill
  input wire logic [NUM_INST-1:0] cmpOut, // Compare out
  input wire logic [NUM_INST-1:0] cmpComp, // Complement out
  input wire logic [NUM_INST-1:0] tcOut, // Terminal count
  input wire logic [NUM_INST-1:0] irqReq, // Unit irq
  input wire logic irq // Combined irq
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  a_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held too long");
  a_ack_next_edge: assert property (clkEn && wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack not one cycle after request");
  a_ack_has_cause: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  a_rdata_holds: assert property (!wb_ack_o ##1 !wb_ack_o |-> $stable(wb_dat_o))
    else $error("read data moved between accesses");
  a_kill_forces_low: assert property (clkEn && |tmrKill |=> ((cmpOut | cmpComp) & $past(tmrKill)) == '0)
    else $error("output active under kill");
  a_no_overlap: assert property ((cmpOut & cmpComp) == '0)
    else $error("both outputs active");
  a_irq_combines: assert property (irq == |irqReq)
    else $error("combined irq differs from unit lines");
  a_freeze_holds: assert property (!clkEn |=> $stable(tcOut) && $stable(cmpOut) && $stable(irq))
    else $error("state moved while frozen");
endmodule
bind tcp_timer_top tcp_timer_props #(.NUM_INST(NUM_INST)) u_props (.clock(clock), .rst_b(rst_b),
  .clkEn(clkEn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .tmrKill(tmrKill), .cmpOut(cmpOut), .cmpComp(cmpComp), .tcOut(tcOut), .irqReq(irqReq), .irq(irq));
`default_nettype wire

// ==== sim/tcp_fabric_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module tcp_fabric_model (
  input wire logic clock, // System clock
  input wire logic rst_b, // Async reset
  input wire logic [3:0] reqEn, // Wanted enable
  input wire logic [3:0] reqRst, // Wanted restart
  input wire logic [3:0] reqCap, // Wanted capture
  input wire logic [3:0] reqKill, // Wanted kill
  output logic [3:0] srcClk, // Routed clock
  output logic [3:0] tmrEn, // Routed enable
  output logic [3:0] tmrRst, // Routed restart
  output logic [3:0] tmrCap, // Routed capture
  output logic [3:0] tmrKill // Routed kill
);
  logic [1:0] div;
  // Routing adds one register stage, as a synchronised fabric path would
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      div <= 2'h0;
      srcClk <= 4'h0;
      {tmrEn, tmrRst, tmrCap, tmrKill} <= 16'h0000;
    end else begin
      div <= div + 2'h1;
      if (div == 2'h3) srcClk <= ~srcClk;
      {tmrEn, tmrRst, tmrCap, tmrKill} <= {reqEn, reqRst, reqCap, reqKill};
    end
  end
endmodule
`default_nettype wire

// ==== sim/tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import tcp_pkg::*;
  localparam logic [7:0] oPer = 8'(TCP_OFS_PERIOD);
  localparam logic [7:0] oCmp = 8'(TCP_OFS_COMPARE);
  localparam logic [7:0] oCnt = 8'(TCP_OFS_COUNT);
  localparam logic [7:0] oCap = 8'(TCP_OFS_CAPTURE);
  localparam logic [7:0] oDead = 8'(TCP_OFS_DEAD);
  logic clock, rst_b, clkEn, cyc, stb, we, ack, irq;
  logic [7:0] adr;
  logic [31:0] wdat, rdat, got, lfsr;
  logic [3:0] fEn, fRst, fCap, fKill, srcClk, tmrEn, tmrRst, tmrCap, tmrKill, cmpOut, cmpComp, tcOut, irqReq;
  int nFail, compares, nTc, tPrev, tGap, a;
  logic [15:0] p;
  time tAck, t1;
  tcp_timer_top #(.PRESCALE(2)) dut (.clock, .rst_b, .clkEn, .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .srcClk, .tmrEn,
    .tmrRst, .tmrCap, .tmrKill, .cmpOut, .cmpComp, .tcOut, .irqReq, .irq);
  tcp_fabric_model fab (.clock, .rst_b, .reqEn(fEn), .reqRst(fRst), .reqCap(fCap), .reqKill(fKill),
    .srcClk, .tmrEn, .tmrRst, .tmrCap, .tmrKill);
  initial begin
    clock = 0;
    forever #2 clock = ~clock;
  end
  always @(posedge clock) if (tcOut[0] === 1'b1) begin
    nTc++;
    tGap = int'($time / 4) - tPrev;
    tPrev = int'($time / 4);
  end
  function automatic logic [31:0] nx(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [31:0] ctl(logic [1:0] m, logic [2:0] r, logic [2:0] ie);
    return {20'h0, ie, 1'b1, 2'b00, r, m, 1'b0};
  endfunction
  function automatic logic relf(int r, int c, int k);
    case (r)
      0: return c < k;
      1: return c <= k;
      2: return c == k;
      3: return c >= k;
      default: return c > k;
    endcase
  endfunction
  task chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      nFail++;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask
  task bus(input logic w, input logic [7:0] ad, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clock);
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= ad;
    wdat <= d;
    do begin
      @(posedge clock);
      n++;
    end while (ack !== 1'b1 && n < 50);
    got = rdat;
    tAck = $time;
    cyc <= 0;
    stb <= 0;
    we <= 0;
    if (n >= 50) chk(0, 1);
  endtask
  task go(input logic [1:0] m, input logic [2:0] r, input logic [2:0] ie);
    bus(1, 0, ctl(m, r, ie));
    bus(1, 0, ctl(m, r, ie) | 1);
  endtask
  task endOfTest;
    $display("fails %0d compares %0d", nFail, compares);
    if (nFail == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clock);
    nFail++;
    endOfTest;
  end
  initial begin
    {rst_b, cyc, stb, we, adr, wdat, fEn, fRst, fCap, fKill} = '0;
    clkEn = 1;
    {nFail, compares, nTc, tPrev, tGap} = '0;
    lfsr = 32'd68995;
    repeat (20) @(posedge clock);
    rst_b <= 1;
    bus(0, oPer, 0); chk(got, 32'hffff);
    bus(0, oCnt, 0); chk(got, 32'hffff);
    bus(0, 8'h9c, 0); chk(got, 0);
    bus(1, oPer, 2);
    go(MODE_FREE, 0, 0);
    repeat (12) @(posedge clock);
    chk(tGap, 3);
    bus(1, 0, 0);
    bus(1, oPer, 3);
    nTc = 0;
    go(MODE_ONESHOT, 0, 0);
    repeat (20) @(posedge clock);
    chk(nTc, 1);
    bus(0, oCnt, 0); chk(got, 3);
    bus(1, 0, 0);
    bus(1, oPer, 32'h8000);
    go(MODE_FREE, 0, 0);
    bus(0, oCnt, 0);
    a = got;
    t1 = tAck;
    // Frozen edges must not count, so they come off the elapsed span
    clkEn <= 0;
    repeat (5) @(posedge clock);
    clkEn <= 1;
    bus(0, oCnt, 0);
    chk(a - got, 32'((tAck - t1) / 4 - 5));
    lfsr = nx(lfsr);
    p = {1'b0, lfsr[14:0]} | 16'h0100;
    bus(1, 0, 0);
    bus(1, oPer, p);
    bus(1, TCP_OFS_IRQ_MASK, 4);
    go(MODE_GATED, CMP_MATCHING, 3'b100);
    repeat (5) @(posedge clock);
    bus(0, oCnt, 0); chk(got, p);
    fEn <= 1;
    repeat (6) @(posedge clock);
    fEn <= 0;
    repeat (3) @(posedge clock);
    bus(0, oCnt, 0); chk(32'(got < p), 1);
    fRst <= 1;
    repeat (3) @(posedge clock);
    fRst <= 0;
    repeat (3) @(posedge clock);
    bus(0, oCnt, 0); chk(got, p);
    chk(irq, 0);
    fCap <= 1;
    repeat (3) @(posedge clock);
    fCap <= 0;
    repeat (4) @(posedge clock);
    bus(0, oCap, 0); chk(got, p);
    chk({irq, irqReq[0]}, 2'b11);
    bus(1, TCP_OFS_IRQ_MASK, 0);
    repeat (3) @(posedge clock);
    chk(irq, 0);
    bus(1, TCP_OFS_IRQ_MASK, 4);
    bus(1, TCP_OFS_IRQ_STATUS, 4);
    repeat (3) @(posedge clock);
    chk(irq, 0);
    for (int r = 0; r < 5; r++) begin
      for (int d = -1; d < 2; d++) begin
        bus(1, oCmp, p + d);
        bus(1, 0, ctl(MODE_GATED, r, 0) | 1);
        repeat (4) @(posedge clock);
        chk(cmpOut[0], relf(r, p, p + d));
        chk(cmpComp[0], !relf(r, p, p + d));
      end
    end
    fKill <= 1;
    repeat (3) @(posedge clock);
    chk({cmpOut[0], cmpComp[0]}, 0);
    fKill <= 0;
    repeat (4) @(posedge clock);
    chk(cmpComp[0], 1);
    bus(1, oDead, 3);
    bus(1, 0, ctl(MODE_GATED, CMP_MATCHING, 0) | 1);
    bus(1, oCmp, p);
    repeat (3) @(posedge clock);
    chk({cmpOut[0], cmpComp[0]}, 0);
    repeat (3) @(posedge clock);
    chk({cmpOut[0], cmpComp[0]}, 2'b10);
    bus(1, 0, 0);
    bus(1, oPer, 2);
    bus(1, 0, ctl(MODE_FREE, 0, 0) | 32'h40);
    bus(1, 0, ctl(MODE_FREE, 0, 0) | 32'h41);
    repeat (30) @(posedge clock);
    chk(tGap, 6);
    bus(1, 0, 0);
    bus(1, TCP_OFS_IRQ_MASK, 1);
    bus(1, 0, ctl(MODE_FREE, 0, 3'b001) | 32'h80);
    bus(1, 0, ctl(MODE_FREE, 0, 3'b001) | 32'h81);
    repeat (80) @(posedge clock);
    chk(tGap, 24);
    chk(irq, 1);
    endOfTest;
  end
endmodule
`default_nettype wire
